// >>> logic/lsat_defs.vh
`ifndef LSAT_DEFS_VH
`define LSAT_DEFS_VH
// =====================================================================
// register offsets
`define LSAT_ADR_STAT1   8'h41
`define LSAT_ADR_STAT2   8'h42
`define LSAT_ADR_STAT3   8'h43
`define LSAT_ADR_MASK1   8'h74
`define LSAT_ADR_MASK2   8'h75
`define LSAT_ADR_CFG3    8'h78
`define LSAT_ADR_TIMER   8'h79
`define LSAT_ADR_TLIM    8'h7A
`define LSAT_ADR_CFG4    8'h7D
`define LSAT_ADR_STAT4   8'h81
`define LSAT_ADR_MASK3   8'h82
`define LSAT_ADR_MASK4   8'h83
// =====================================================================
// reset values
`define LSAT_RST_MASK    8'h00
`define LSAT_RST_CFG3    8'h00
`define LSAT_RST_CFG4    8'h00
`define LSAT_RST_TLIM    8'h00
// =====================================================================
// field positions
`define LSAT_CFG3_ALERT  0
`define LSAT_CFG3_THREN  1
`define LSAT_CFG3_FULL_SPEED_OVERRIDE  2
`define LSAT_CHAIN1      7
`define LSAT_CHAIN2      1
`define LSAT_CHAIN3      7
`define LSAT_TIMER_BIT   5
`define LSAT_VOLT_BIT    0
// live flag bits of each status register (chain and reserved excluded)
`define LSAT_LIVE1       8'h7F
`define LSAT_LIVE2       8'hFD
`define LSAT_LIVE3       8'h0F
`define LSAT_LIVE4       8'hF8
// multipurpose pin function codes {bit1,bit0}
`define LSAT_MP_TACH     2'h0
`define LSAT_MP_ALERT    2'h1
`define LSAT_MP_THROT    2'h2
// =====================================================================
// timing: timer lsb weight and clock period, in ns
`define LSAT_TICK_NS     22760000
`define LSAT_CLK_NS      25
`define LSAT_FULL        8'hFF
`endif

// >>> logic/lsat_sync.v
`timescale 1ns/1ps
`include "lsat_defs.vh"
// =====================================================================
// two flip-flop synchroniser for pin levels
module lsat_sync #(
   parameter W = 2
) (
   input  wire         sys_clk,
   input  wire         nrst,
   input  wire [W-1:0] d,
   output wire [W-1:0] q
);
   reg [W-1:0] meta_r;
   reg [W-1:0] sync_r;

   // first stage feeds only the second; pins idle high
   always @(posedge sys_clk) begin
      if (!nrst) begin
         meta_r <= {W{1'b1}};
         sync_r <= {W{1'b1}};
      end else begin
         meta_r <= d;
         sync_r <= meta_r;
      end
   end

   assign q = sync_r;
endmodule

// >>> logic/lsat_timer.v
`timescale 1ns/1ps
`include "lsat_defs.vh"
// =====================================================================
// accumulating throttle assertion timer, cleared on read
module lsat_timer #(
   parameter TICK_CYC = `LSAT_TICK_NS / `LSAT_CLK_NS
) (
   input  wire       sys_clk,
   input  wire       nrst,
   input  wire       thr_act,
   input  wire       rd_clr,
   output wire [7:0] value
);
   reg [19:0] sub_r;
   reg [7:0]  cnt_r;
   reg        seen_r;

   // sub-tick prescaler and tick counter, paused while released
   always @(posedge sys_clk) begin
      if (!nrst) begin
         sub_r  <= 20'h00000;
         cnt_r  <= 8'h00;
         seen_r <= 1'b0;
      end else if (rd_clr) begin
         sub_r  <= 20'h00000;
         cnt_r  <= 8'h00;
         seen_r <= thr_act;
      end else if (thr_act) begin
         seen_r <= 1'b1;
         if (cnt_r != `LSAT_FULL) begin
            if (sub_r == TICK_CYC[19:0] - 20'h00001) begin
               sub_r <= 20'h00000;
               cnt_r <= cnt_r + 8'h01;
            end else begin
               sub_r <= sub_r + 20'h00001;
            end
         end
      end
   end

   // below two ticks only the first-assertion bit shows
   assign value = (cnt_r[7:1] != 7'h00) ? cnt_r : {7'h00, seen_r};
endmodule

// >>> logic/lsat_top.v
`timescale 1ns/1ps
`include "lsat_defs.vh"
// How it works
// - a channel out of its limits sets its status flag to one
// - chaining bit reads one when the next status register has any flag
// - flags are sticky; a read clears only flags whose condition is gone
// - four status registers, each paired with a mask of same bit layout
// - a set mask bit blocks alert but the flag still sets
// - alert low while any unmasked source is out or its flag unread
// - alert off after reset; config bit 0 moves shared pin from pwm to alert
// - two config bits pick tach, throttle, alert or reserved on multipurpose pin
// - throttle enable makes dedicated pin and chosen multipurpose pin throttle inputs
// - override bit drives running fans to full duty while throttle held low
// - fans with zero manual duty or, in auto mode, below minimum temperature are untouched
// - timer runs only while throttle asserted, pauses and resumes
// - timer clears on read and holds at full scale
// - bit 0 marks first assertion; past two ticks the value is a tick count
// - read during assertion clears, sets bit 0, restarts; zero limit flags at once
// - timer above its limit sets bit 5 of the second status register
module lsat_top #(
   parameter TICK_CYC = `LSAT_TICK_NS / `LSAT_CLK_NS
) (
   input  wire        sys_clk,
   input  wire        nrst,
   input  wire [7:0]  reg_addr,
   input  wire [7:0]  reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [7:0]  reg_rdata,
   input  wire [7:0]  ool_one,
   input  wire [7:0]  ool_two,
   input  wire [7:0]  ool_three,
   input  wire [7:0]  ool_four,
   input  wire        second_pwm_output,
   output reg         shared_pin_o,
   output reg         shared_pin_oe_n,
   input  wire        throttle_pin_n,
   input  wire        mp_pin_i,
   output reg         mp_pin_o,
   output reg         mp_pin_oe_n,
   output wire        fourth_tach_input,
   input  wire [2:0]  fan_manual,
   input  wire [23:0] fan_manual_duty,
   input  wire [2:0]  fan_above_tmin,
   output reg  [2:0]  full_speed_override,
   output wire        alert_active
);
   // =================================================================
   // control registers
   reg  [7:0] mask1_r;
   reg  [7:0] mask2_r;
   reg  [7:0] mask3_r;
   reg  [7:0] mask4_r;
   reg  [7:0] cfg3_r;
   reg  [7:0] cfg4_r;
   reg  [7:0] tlim_r;
   reg  [7:0] flag1_r;
   reg  [7:0] flag2_r;
   reg  [7:0] flag3_r;
   reg  [7:0] flag4_r;
   reg  [7:0] flag1_nxt;
   reg  [7:0] flag2_nxt;
   reg  [7:0] flag3_nxt;
   reg  [7:0] flag4_nxt;
   reg  [7:0] cond1;
   reg  [7:0] cond2;
   reg  [7:0] cond3;
   reg  [7:0] cond4;
   wire [1:0] pins_s;
   wire [7:0] timer_val;
   wire       rd1;
   wire       rd2;
   wire       rd3;
   wire       rd4;
   wire       rd_tmr;
   wire       thr_en;
   wire       mp_thr;
   wire       mp_alert;
   wire       thr_act;
   wire       tmr_over;
   wire [7:0] stat1_view;
   wire [7:0] stat2_view;
   wire [7:0] stat3_view;
   wire [7:0] stat4_view;
   wire [2:0] fan_run;
   wire       mp_tach;
   wire       full_speed_override_on;

   // =================================================================
   // helpers

   // sticky flag: condition sets, read clears only a gone condition
   function [7:0] sticky;
      input [7:0] flag;
      input [7:0] cond;
      input       rd;
      begin
         sticky = cond | (flag & ~{8{rd}});
      end
   endfunction

   // any flagged source that its mask lets through
   function unmasked;
      input [7:0] flag;
      input [7:0] cond;
      input [7:0] mask;
      input [7:0] live;
      begin
         unmasked = |((flag | cond) & ~mask & live);
      end
   endfunction

   // a fan counts as running at nonzero manual duty or above its auto minimum
   function fan_running;
      input       manual;
      input [7:0] duty;
      input       above;
      begin
         fan_running = manual ? (duty != 8'h00) : above;
      end
   endfunction

   // =================================================================
   // register access strobes
   assign rd1    = reg_rd && (reg_addr == `LSAT_ADR_STAT1);
   assign rd2    = reg_rd && (reg_addr == `LSAT_ADR_STAT2);
   assign rd3    = reg_rd && (reg_addr == `LSAT_ADR_STAT3);
   assign rd4    = reg_rd && (reg_addr == `LSAT_ADR_STAT4);
   assign rd_tmr = reg_rd && (reg_addr == `LSAT_ADR_TIMER);

   // =================================================================
   // throttle pin selection
   assign thr_en   = cfg3_r[`LSAT_CFG3_THREN];
   assign mp_thr   = (cfg4_r[1:0] == `LSAT_MP_THROT);
   assign mp_alert = (cfg4_r[1:0] == `LSAT_MP_ALERT);
   assign mp_tach  = (cfg4_r[1:0] == `LSAT_MP_TACH);

   // pins are active low; both cross into the clock domain first
   lsat_sync #(
      .W (2)
   ) u_sync (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .d       ({mp_pin_i, throttle_pin_n}),
      .q       (pins_s)
   );

   // dedicated pin always, multipurpose pin when so configured
   assign thr_act = thr_en && (!pins_s[0] || (mp_thr && !pins_s[1]));

   // tach input only passes when the multipurpose pin is a tach
   assign fourth_tach_input = mp_tach ? pins_s[1] : 1'b1;

   // =================================================================
   // throttle timer
   lsat_timer #(
      .TICK_CYC (TICK_CYC)
   ) u_timer (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .thr_act (thr_act),
      .rd_clr  (rd_tmr),
      .value   (timer_val)
   );

   // limit compare; a zero limit trips on the first assertion
   assign tmr_over = thr_en && (timer_val > tlim_r);

   // =================================================================
   // flag conditions per status register
   always @* begin
      cond1 = ool_one & `LSAT_LIVE1;
      cond2 = ool_two & `LSAT_LIVE2;
      cond3 = ool_three & `LSAT_LIVE3;
      cond4 = ool_four & `LSAT_LIVE4;
      // dedicated pin no longer measures voltage when it throttles
      if (thr_en) begin
         cond1[`LSAT_VOLT_BIT] = tmr_over;
         cond2[`LSAT_TIMER_BIT] = tmr_over;
      end else if (!mp_tach) begin
         cond2[`LSAT_TIMER_BIT] = 1'b0;
      end
   end

   // next flags: set beats the clearing read
   always @* begin
      flag1_nxt = sticky(flag1_r, cond1, rd1);
      flag2_nxt = sticky(flag2_r, cond2, rd2);
      flag3_nxt = sticky(flag3_r, cond3, rd3);
      flag4_nxt = sticky(flag4_r, cond4, rd4);
   end

   // chaining bits are derived from the next register's flags
   assign stat4_view = flag4_r & `LSAT_LIVE4;
   assign stat3_view = (flag3_r & `LSAT_LIVE3) | {|stat4_view, 7'h00};
   assign stat2_view = (flag2_r & `LSAT_LIVE2) | {6'h00, |stat3_view, 1'b0};
   assign stat1_view = (flag1_r & `LSAT_LIVE1) | {|stat2_view, 7'h00};

   // =================================================================
   // registers written by the host, and status flags
   always @(posedge sys_clk) begin
      if (!nrst) begin
         mask1_r <= `LSAT_RST_MASK;
         mask2_r <= `LSAT_RST_MASK;
         mask3_r <= `LSAT_RST_MASK;
         mask4_r <= `LSAT_RST_MASK;
         cfg3_r  <= `LSAT_RST_CFG3;
         cfg4_r  <= `LSAT_RST_CFG4;
         tlim_r  <= `LSAT_RST_TLIM;
         flag1_r <= 8'h00;
         flag2_r <= 8'h00;
         flag3_r <= 8'h00;
         flag4_r <= 8'h00;
      end else begin
         flag1_r <= flag1_nxt;
         flag2_r <= flag2_nxt;
         flag3_r <= flag3_nxt;
         flag4_r <= flag4_nxt;
         if (reg_wr) begin
            case (reg_addr)
               `LSAT_ADR_MASK1: mask1_r <= reg_wdata;
               `LSAT_ADR_MASK2: mask2_r <= reg_wdata;
               `LSAT_ADR_MASK3: mask3_r <= reg_wdata;
               `LSAT_ADR_MASK4: mask4_r <= reg_wdata;
               `LSAT_ADR_CFG3:  cfg3_r  <= reg_wdata;
               `LSAT_ADR_CFG4:  cfg4_r  <= reg_wdata;
               `LSAT_ADR_TLIM:  tlim_r  <= reg_wdata;
               default: ;
            endcase
         end
      end
   end

   // =================================================================
   // read data, captured before the read clears anything
   always @(posedge sys_clk) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `LSAT_ADR_STAT1: reg_rdata <= stat1_view;
            `LSAT_ADR_STAT2: reg_rdata <= stat2_view;
            `LSAT_ADR_STAT3: reg_rdata <= stat3_view;
            `LSAT_ADR_STAT4: reg_rdata <= stat4_view;
            `LSAT_ADR_MASK1: reg_rdata <= mask1_r;
            `LSAT_ADR_MASK2: reg_rdata <= mask2_r;
            `LSAT_ADR_MASK3: reg_rdata <= mask3_r;
            `LSAT_ADR_MASK4: reg_rdata <= mask4_r;
            `LSAT_ADR_CFG3:  reg_rdata <= cfg3_r;
            `LSAT_ADR_CFG4:  reg_rdata <= cfg4_r;
            `LSAT_ADR_TLIM:  reg_rdata <= tlim_r;
            `LSAT_ADR_TIMER: reg_rdata <= timer_val;
            default:         reg_rdata <= 8'h00;
         endcase
      end
   end

   // =================================================================
   // alert: any unmasked flag or live condition
   assign alert_active = unmasked(flag1_r, cond1, mask1_r, `LSAT_LIVE1) |
                         unmasked(flag2_r, cond2, mask2_r, `LSAT_LIVE2) |
                         unmasked(flag3_r, cond3, mask3_r, `LSAT_LIVE3) |
                         unmasked(flag4_r, cond4, mask4_r, `LSAT_LIVE4);

   // =================================================================
   // pin drivers; alert is open drain, pwm is push-pull
   always @(posedge sys_clk) begin
      if (!nrst) begin
         shared_pin_o    <= 1'b0;
         shared_pin_oe_n <= 1'b0;
         mp_pin_o        <= 1'b1;
         mp_pin_oe_n     <= 1'b1;
      end else begin
         if (cfg3_r[`LSAT_CFG3_ALERT]) begin
            shared_pin_o    <= 1'b0;
            shared_pin_oe_n <= ~alert_active;
         end else begin
            shared_pin_o    <= second_pwm_output;
            shared_pin_oe_n <= 1'b0;
         end
         mp_pin_o    <= 1'b0;
         mp_pin_oe_n <= ~(mp_alert && alert_active);
      end
   end

   // =================================================================
   // full speed override for fans that are already running
   assign full_speed_override_on = cfg3_r[`LSAT_CFG3_FULL_SPEED_OVERRIDE] && thr_act;

   // running state of each fan
   assign fan_run[0] = fan_running(fan_manual[0], fan_manual_duty[7:0], fan_above_tmin[0]);
   assign fan_run[1] = fan_running(fan_manual[1], fan_manual_duty[15:8], fan_above_tmin[1]);
   assign fan_run[2] = fan_running(fan_manual[2], fan_manual_duty[23:16], fan_above_tmin[2]);

   // registered so the fan logic sees a clean level
   always @(posedge sys_clk) begin
      if (!nrst) begin
         full_speed_override <= 3'h0;
      end else begin
         full_speed_override <= {3{full_speed_override_on}} & fan_run;
      end
   end

endmodule

// >>> tb/lsat_asserts.sv
`timescale 1ns/1ps
// =====================================================================
// checker on the top ports
module lsat_asserts (
   input wire        sys_clk,
   input wire        nrst,
   input wire [7:0]  reg_addr,
   input wire        reg_rd,
   input wire [7:0]  reg_rdata,
   input wire        second_pwm_output,
   input wire        shared_pin_o,
   input wire        shared_pin_oe_n,
   input wire        throttle_pin_n,
   input wire        mp_pin_i,
   input wire        mp_pin_o,
   input wire        mp_pin_oe_n,
   input wire [2:0]  fan_manual,
   input wire [23:0] fan_manual_duty,
   input wire [2:0]  fan_above_tmin,
   input wire [2:0]  full_speed_override,
   input wire        alert_active
);
   // fans turning, by manual duty or by automatic threshold
   wire [2:0] run = fan_manual & {|fan_manual_duty[23:16], |fan_manual_duty[15:8],
                    |fan_manual_duty[7:0]} | ~fan_manual & fan_above_tmin;
   // =====================================================================
   // assertions
   chk_reset_state: assert property (@(posedge sys_clk) !nrst |=>
      !shared_pin_oe_n && mp_pin_oe_n && full_speed_override == 3'h0 && reg_rdata == 8'h00)
      else $error("outputs not idle after reset");
   chk_pwm_share: assert property (@(posedge sys_clk) disable iff (!nrst)
      !shared_pin_oe_n && shared_pin_o |-> $past(second_pwm_output))
      else $error("shared pin high without pwm");
   chk_mp_drive_low: assert property (@(posedge sys_clk) disable iff (!nrst)
      !mp_pin_oe_n |-> !mp_pin_o)
      else $error("multipurpose pin driven high");
   chk_mp_alert_cause: assert property (@(posedge sys_clk) disable iff (!nrst)
      !mp_pin_oe_n |-> $past(alert_active))
      else $error("multipurpose pin driven without alert");
   chk_override_fan: assert property (@(posedge sys_clk) disable iff (!nrst)
      (full_speed_override & ~$past(run)) == 3'h0)
      else $error("override on a stopped fan");
   chk_override_cause: assert property (@(posedge sys_clk) disable iff (!nrst)
      $rose(|full_speed_override) |-> !$past(throttle_pin_n, 3) || !$past(mp_pin_i, 3))
      else $error("override without synchronised throttle");
   chk_override_drop: assert property (@(posedge sys_clk) disable iff (!nrst)
      (throttle_pin_n && mp_pin_i) [*3] |=> full_speed_override == 3'h0)
      else $error("override kept after throttle release");
   chk_rdata_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without read");
   chk_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
      reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule

bind lsat_top lsat_asserts chk (
   .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .second_pwm_output(second_pwm_output),
   .shared_pin_o(shared_pin_o), .shared_pin_oe_n(shared_pin_oe_n),
   .throttle_pin_n(throttle_pin_n), .mp_pin_i(mp_pin_i), .mp_pin_o(mp_pin_o),
   .mp_pin_oe_n(mp_pin_oe_n), .fan_manual(fan_manual), .fan_manual_duty(fan_manual_duty),
   .fan_above_tmin(fan_above_tmin), .full_speed_override(full_speed_override),
   .alert_active(alert_active)
);

// >>> tb/lsat_far.sv
`timescale 1ns/1ps
// =====================================================================
// far side: comparators, fan logic, throttle source and pulled-up pin
module lsat_far (
   input  wire        sys_clk,
   input  wire [31:0] ool_set,
   input  wire        thr_set,
   input  wire        mp_set,
   input  wire        mp_o,
   input  wire        mp_oe_n,
   input  wire [2:0]  man_set,
   input  wire [23:0] duty_set,
   input  wire [2:0]  tmin_set,
   output wire [31:0] next_register_flagged,
   output reg         pwm,
   output wire        thr_n,
   output wire        mp_lvl,
   output wire [2:0]  fan_man,
   output wire [23:0] fan_duty,
   output wire [2:0]  fan_tmin
);
   // comparator levels, fan state and throttle source follow the bench
   assign next_register_flagged      = ool_set;
   assign thr_n    = thr_set;
   assign fan_man  = man_set;
   assign fan_duty = duty_set;
   assign fan_tmin = tmin_set;
   // pulled-up node: low when the source or the enabled device pulls it
   assign mp_lvl   = mp_set & (mp_oe_n | mp_o);
   // fan pwm runs free
   initial pwm = 1'b0;
   always @(posedge sys_clk) begin
      pwm <= ~pwm;
   end
endmodule

// >>> tb/lsat_top_tb.sv
`timescale 1ns/1ps
// =====================================================================
// register level bench
module lsat_top_tb;
   reg         sys_clk = 1'b0;
   reg         nrst = 1'b0;
   reg  [7:0]  reg_addr = 8'h00;
   reg  [7:0]  reg_wdata = 8'h00;
   reg         reg_wr = 1'b0;
   reg         reg_rd = 1'b0;
   wire [7:0]  reg_rdata;
   wire [31:0] next_register_flagged;
   wire        pwm, thr_n, mp_lvl, sh_o, sh_oe_n, mp_o, mp_oe_n, tach, alert;
   wire [2:0]  fan_man, fan_tmin, fso;
   wire [23:0] fan_duty;
   reg  [31:0] ool_set = 32'h0;
   reg         thr_set = 1'b1;
   reg         mp_set = 1'b1;
   reg  [2:0]  man_set = 3'h0;
   reg  [23:0] duty_set = 24'h0;
   reg  [2:0]  tmin_set = 3'h0;
   int         n_mismatch = 0;
   int         cmp_count = 0;
   logic [7:0] ra [13] = '{8'h41, 8'h42, 8'h43, 8'h81, 8'h74, 8'h75, 8'h82, 8'h83,
                           8'h78, 8'h79, 8'h7D, 8'h7A, 8'h00};
   always #12.5 sys_clk = ~sys_clk;
   lsat_far far (.sys_clk(sys_clk), .ool_set(ool_set), .thr_set(thr_set), .mp_set(mp_set),
      .mp_o(mp_o), .mp_oe_n(mp_oe_n), .man_set(man_set), .duty_set(duty_set),
      .tmin_set(tmin_set), .next_register_flagged(next_register_flagged), .pwm(pwm), .thr_n(thr_n), .mp_lvl(mp_lvl),
      .fan_man(fan_man), .fan_duty(fan_duty), .fan_tmin(fan_tmin));
   lsat_top #(.TICK_CYC(8)) uut (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ool_one(next_register_flagged[7:0]), .ool_two(next_register_flagged[15:8]), .ool_three(next_register_flagged[23:16]),
      .ool_four(next_register_flagged[31:24]), .second_pwm_output(pwm), .shared_pin_o(sh_o),
      .shared_pin_oe_n(sh_oe_n), .throttle_pin_n(thr_n), .mp_pin_i(mp_lvl), .mp_pin_o(mp_o),
      .mp_pin_oe_n(mp_oe_n), .fourth_tach_input(tach), .fan_manual(fan_man),
      .fan_manual_duty(fan_duty), .fan_above_tmin(fan_tmin), .full_speed_override(fso),
      .alert_active(alert));
   // =====================================================================
   // access and compare tasks
   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input [7:0] a, input [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask
   // far side levels change just after an edge
   task set_ool(input [31:0] v);
      @(posedge sys_clk);
      ool_set <= v;
   endtask
   task set_thr(input v);
      @(posedge sys_clk);
      thr_set <= v;
   endtask
   task set_mp(input v);
      @(posedge sys_clk);
      mp_set <= v;
   endtask
   task set_fan(input [2:0] m, input [23:0] d, input [2:0] t);
      @(posedge sys_clk);
      man_set <= m;
      duty_set <= d;
      tmin_set <= t;
   endtask
   task pulse(input [31:0] v);
      set_ool(v);
      set_ool(32'h0);
      cyc(2);
   endtask
   task results;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (10000) @(posedge sys_clk);
      n_mismatch++;
      results;
   end
   // =====================================================================
   // test sequence
   initial begin
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      foreach (ra[i]) rd(ra[i], 8'h00);
      for (int i = 4; i < 8; i++) begin
         wr(ra[i], 8'h5A);
         rd(ra[i], 8'h5A);
         wr(ra[i], 8'h00);
      end
      wr(8'h41, 8'hFF);
      rd(8'h41, 8'h00);
      // sticky flags, and a read while the condition holds
      pulse(32'h10);
      rd(8'h41, 8'h10);
      rd(8'h41, 8'h00);
      set_ool(32'h10);
      cyc(2);
      rd(8'h41, 8'h10);
      rd(8'h41, 8'h10);
      set_ool(32'h0);
      rd(8'h41, 8'h10);
      rd(8'h41, 8'h00);
      // chaining through all four registers
      pulse(32'h80000000);
      rd(8'h41, 8'h80);
      rd(8'h42, 8'h02);
      rd(8'h43, 8'h80);
      rd(8'h81, 8'h80);
      rd(8'h41, 8'h00);
      // masked then unmasked source on the alert pins
      wr(8'h78, 8'h01);
      wr(8'h74, 8'h10);
      pulse(32'h10);
      chk({7'h0, alert}, 8'h00);
      rd(8'h41, 8'h10);
      wr(8'h74, 8'h00);
      pulse(32'h10);
      chk({7'h0, alert}, 8'h01);
      chk({6'h0, sh_oe_n, sh_o}, 8'h00);
      wr(8'h7D, 8'h01);
      cyc(2);
      chk({7'h0, mp_oe_n}, 8'h00);
      rd(8'h41, 8'h10);
      cyc(2);
      chk({6'h0, alert, sh_oe_n}, 8'h01);
      wr(8'h7D, 8'h00);
      set_mp(1'b0);
      cyc(4);
      chk({7'h0, tach}, 8'h00);
      set_mp(1'b1);
      // throttle off, then on with override and timer
      set_fan(3'b011, 24'h000040, 3'b100);
      wr(8'h78, 8'h04);
      set_thr(1'b0);
      cyc(8);
      chk({5'h0, fso}, 8'h00);
      set_thr(1'b1);
      rd(8'h79, 8'h00);
      wr(8'h78, 8'h06);
      set_thr(1'b0);
      cyc(4);
      chk({5'h0, fso}, 8'h05);
      set_thr(1'b1);
      cyc(4);
      chk({5'h0, fso}, 8'h00);
      rd(8'h79, 8'h01);
      rd(8'h79, 8'h00);
      rd(8'h42, 8'h20);
      rd(8'h42, 8'h00);
      rd(8'h41, 8'h01);
      set_thr(1'b0);
      cyc(19);
      set_thr(1'b1);
      cyc(20);
      set_thr(1'b0);
      cyc(15);
      set_thr(1'b1);
      cyc(4);
      rd(8'h79, 8'h04);
      set_thr(1'b0);
      cyc(2100);
      rd(8'h79, 8'hFF);
      rd(8'h79, 8'h01);
      set_thr(1'b1);
      cyc(4);
      rd(8'h79, 8'h01);
      rd(8'h42, 8'h20);
      rd(8'h41, 8'h01);
      // nonzero limit, timed on the multipurpose pin
      wr(8'h7A, 8'h02);
      rd(8'h7A, 8'h02);
      wr(8'h7D, 8'h02);
      set_mp(1'b0);
      cyc(6);
      chk({5'h0, fso}, 8'h05);
      cyc(11);
      set_mp(1'b1);
      cyc(4);
      rd(8'h42, 8'h00);
      set_mp(1'b0);
      cyc(7);
      set_mp(1'b1);
      cyc(4);
      rd(8'h42, 8'h20);
      rd(8'h79, 8'h03);
      rd(8'h42, 8'h20);
      rd(8'h42, 8'h00);
      rd(8'h41, 8'h01);
      // reserved code: no throttle, tach held high
      wr(8'h7D, 8'h03);
      set_mp(1'b0);
      cyc(6);
      chk({4'h0, fso, tach}, 8'h01);
      set_mp(1'b1);
      cyc(4);
      rd(8'h79, 8'h00);
      // shared pin relays the pwm one cycle late
      repeat (2) begin
         cyc(1);
         chk({6'h0, sh_oe_n, sh_o}, {6'h0, 1'b0, ~pwm});
      end
      // reset again in mid-run
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      rd(8'h78, 8'h00);
      rd(8'h7A, 8'h00);
      results;
   end
endmodule
